// ### hw/strap_cfg_pkg.sv
// Constants, field layouts and types for the strap capture block.
// Assumes one 10 MHz system clock and a plain register port.
package strap_cfg_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int CLK_PERIOD_NS = 100;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [3:0] OFF_STRAP = 4'h0;
   localparam logic [3:0] OFF_CAUSE = 4'h4;
   localparam logic [3:0] OFF_MASK = 4'h8;
   localparam logic [3:0] OFF_RSTAT = 4'hc;

   ////////////////////////////////////////////////////////////////////////
   // Captured strap vector layout
   localparam int STRAP_W = 9;
   localparam int BIT_RATIO = 0;
   localparam int RATIO_W = 3;
   localparam int BIT_BYTE_ORDER = 3;
   localparam int BIT_BUS_WIDTH = 4;
   localparam int BIT_IRQ_SOURCE = 5;
   localparam int BIT_VALID_DELAY = 6;
   localparam int BIT_BLOCK_XFER = 7;
   localparam int BIT_RETURN_ORDER = 8;
   localparam logic [8:0] STRAP_RESET = 9'h000;

   // Decoded fields in the status word above the raw straps
   localparam int BIT_PROTOCOL = 9;
   localparam int BIT_BLOCK_EN = 12;
   localparam int BIT_RATIO_X2 = 16;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt cause layout
   localparam int IRQ_LINES = 6;
   localparam int CAUSE_W = 8;
   localparam int BIT_LINE5 = 5;
   localparam int BIT_CAUSE7 = 7;
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] CAUSE_RECOG = 8'h9f;

   // Reset event flags
   localparam int BIT_COLD_SEEN = 0;
   localparam int BIT_WARM_SEEN = 1;
   localparam logic [1:0] RSTAT_RESET = 2'h0;

   // Reset and line pins after reset: resets asserted, lines idle high
   localparam logic [8:0] PIN_SYNC_RESET = 9'h07f;

   // Ratio doubled: code 0 gives 2, i.e. 4 half steps
   localparam logic [3:0] RATIO_BASE_X2 = 4'h4;

   typedef enum logic [2:0] {
      PROTO_LEGACY_WIDE,
      PROTO_LEGACY_NARROW,
      PROTO_NATIVE,
      PROTO_OUT_OF_ORDER,
      PROTO_UNLISTED
   } protocol_t;

   function automatic logic [3:0] ratio_x2(input logic [2:0] code);
      ratio_x2 = RATIO_BASE_X2 + {1'b0, code};
   endfunction

endpackage

// ### hw/sync_bits.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes inputs are quasi-static or single-bit levels.
`timescale 1ns/1ps
module sync_bits #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   if (W < 1) begin : g_bad_width
      $error("sync_bits width must be at least one");
   end

   // First stage feeds only the second
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule

// ### hw/strap_decode.sv
// Pure decode of a captured strap vector into configuration fields.
// Assumes the caller registers the results.
`timescale 1ns/1ps
module strap_decode (
   input wire logic [8:0] i_strap,
   output logic [3:0] o_ratio_x2,
   output logic o_big_endian,
   output logic o_bus_64,
   output logic o_timer_on_bit7,
   output logic o_valid_hold,
   output logic o_block_xfer_en,
   output logic o_in_order,
   output strap_cfg_pkg::protocol_t o_protocol
);
   logic ro;
   logic bx;
   logic vd;
   logic bw;

   assign ro = i_strap[strap_cfg_pkg::BIT_RETURN_ORDER];
   assign bx = i_strap[strap_cfg_pkg::BIT_BLOCK_XFER];
   assign vd = i_strap[strap_cfg_pkg::BIT_VALID_DELAY];
   assign bw = i_strap[strap_cfg_pkg::BIT_BUS_WIDTH];

   assign o_ratio_x2 = strap_cfg_pkg::ratio_x2(
      i_strap[strap_cfg_pkg::BIT_RATIO +: strap_cfg_pkg::RATIO_W]);
   assign o_big_endian = i_strap[strap_cfg_pkg::BIT_BYTE_ORDER];
   assign o_bus_64 = bw;
   assign o_timer_on_bit7 = i_strap[strap_cfg_pkg::BIT_IRQ_SOURCE];
   assign o_valid_hold = vd;
   // Low strap enables, and only a narrow bus honours it
   assign o_block_xfer_en = !bx && !bw;
   assign o_in_order = ro;

   always_comb begin
      if (!ro) begin
         o_protocol = strap_cfg_pkg::PROTO_OUT_OF_ORDER;
      end else if (bx && vd && bw) begin
         o_protocol = strap_cfg_pkg::PROTO_LEGACY_WIDE;
      end else if (bx && vd && !bw) begin
         o_protocol = strap_cfg_pkg::PROTO_LEGACY_NARROW;
      end else if (!bx && !vd && !bw) begin
         o_protocol = strap_cfg_pkg::PROTO_NATIVE;
      end else begin
         o_protocol = strap_cfg_pkg::PROTO_UNLISTED;
      end
   end
endmodule

// ### hw/reset_strap_config_capture.sv
// Reset-time strap capture, reset handling and interrupt input front end.
// Assumes straps, resets and interrupt lines arrive on board pins and
// that address issue, stall, timer and write-bit events are on-clock.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module reset_strap_config_capture (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_clock_ratio_strap,
   input wire logic i_byte_order_strap,
   input wire logic i_bus_width_strap,
   input wire logic i_irq_source_strap,
   input wire logic i_valid_delay_strap_n,
   input wire logic i_block_xfer_strap_n,
   input wire logic i_return_order_strap_n,
   input wire logic i_cold_reset_n,
   input wire logic i_warm_reset_n,
   input wire logic [5:0] i_irq_line_n,
   input wire logic i_nmi_n,
   input wire logic i_timer_irq,
   input wire logic i_ext_write_bit5,
   input wire logic i_addr_issue,
   input wire logic i_addr_stall,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic [3:0] o_clock_ratio_x2,
   output logic o_big_endian,
   output logic o_bus_64,
   output logic o_high_half_en,
   output logic o_block_xfer_en,
   output logic o_valid_hold,
   output logic o_in_order,
   output logic [2:0] o_protocol,
   output logic o_cold_init,
   output logic o_warm_init,
   output logic o_output_valid_n,
   output logic [7:0] o_cause,
   output logic o_irq_req,
   output logic o_nmi_req
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [8:0] strap_pins;
   logic [8:0] strap_sync;
   logic [1:0] rst_sync;
   logic [6:0] irq_sync;

   assign strap_pins = {i_return_order_strap_n, i_block_xfer_strap_n,
      i_valid_delay_strap_n, i_irq_source_strap, i_bus_width_strap,
      i_byte_order_strap, i_clock_ratio_strap};

   sync_bits #(.W(9), .RESET_VAL(strap_cfg_pkg::STRAP_RESET)) u_strap_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_async(strap_pins),
      .o_sync(strap_sync)
   );

   // Resets come up asserted so capture runs until the pins say otherwise;
   // lines come up idle, else a false request follows every reset
   sync_bits #(.W(9), .RESET_VAL(strap_cfg_pkg::PIN_SYNC_RESET))
      u_rst_irq_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_async({i_cold_reset_n, i_warm_reset_n, i_nmi_n, i_irq_line_n}),
      .o_sync({rst_sync, irq_sync})
   );

   ////////////////////////////////////////////////////////////////////////
   // Strap capture and reset state

   logic cold_act;
   logic warm_act;
   logic [8:0] strap_reg;
   logic [8:0] strap_next;
   logic [1:0] rstat_reg;
   logic [1:0] rstat_next;
   logic [1:0] rstat_clr;
   logic [3:0] ratio_d;
   logic big_d;
   logic bus64_d;
   logic timer7_d;
   logic hold_d;
   logic block_d;
   logic inord_d;
   strap_cfg_pkg::protocol_t proto_d;
   strap_cfg_pkg::protocol_t proto_reg;
   logic [3:0] ratio_reg;
   logic big_reg;
   logic bus64_reg;
   logic timer7_reg;
   logic hold_reg;
   logic block_reg;
   logic inord_reg;

   assign cold_act = !rst_sync[1];
   assign warm_act = !rst_sync[0];

   strap_decode u_decode (
      .i_strap(strap_next),
      .o_ratio_x2(ratio_d),
      .o_big_endian(big_d),
      .o_bus_64(bus64_d),
      .o_timer_on_bit7(timer7_d),
      .o_valid_hold(hold_d),
      .o_block_xfer_en(block_d),
      .o_in_order(inord_d),
      .o_protocol(proto_d)
   );

   always_comb begin
      // Later pin changes are ignored once cold reset lifts
      strap_next = cold_act ? strap_sync : strap_reg;
      rstat_clr = 2'h0;
      if (i_wr && i_addr == strap_cfg_pkg::OFF_RSTAT) begin
         rstat_clr = i_wdata[1:0];
      end
      // Set wins over a clear in the same cycle
      rstat_next = (rstat_reg & ~rstat_clr) | {warm_act, cold_act};
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         strap_reg <= strap_cfg_pkg::STRAP_RESET;
         rstat_reg <= strap_cfg_pkg::RSTAT_RESET;
         ratio_reg <= strap_cfg_pkg::RATIO_BASE_X2;
         big_reg <= 1'b0;
         bus64_reg <= 1'b0;
         timer7_reg <= 1'b0;
         hold_reg <= 1'b0;
         block_reg <= 1'b0;
         inord_reg <= 1'b0;
         proto_reg <= strap_cfg_pkg::PROTO_OUT_OF_ORDER;
      end else begin
         strap_reg <= strap_next;
         rstat_reg <= rstat_next;
         ratio_reg <= ratio_d;
         big_reg <= big_d;
         bus64_reg <= bus64_d;
         timer7_reg <= timer7_d;
         hold_reg <= hold_d;
         block_reg <= block_d;
         inord_reg <= inord_d;
         proto_reg <= proto_d;
      end
   end

   assign o_clock_ratio_x2 = ratio_reg;
   assign o_big_endian = big_reg;
   assign o_bus_64 = bus64_reg;
   assign o_high_half_en = bus64_reg;
   assign o_block_xfer_en = block_reg;
   assign o_valid_hold = hold_reg;
   assign o_in_order = inord_reg;
   assign o_protocol = proto_reg;
   assign o_cold_init = cold_act;
   assign o_warm_init = warm_act;

   // Issue cycle always valid; stall cycles only when held
   assign o_output_valid_n = !(i_addr_issue || (hold_reg && i_addr_stall));

   ////////////////////////////////////////////////////////////////////////
   // Interrupt front end

   logic [7:0] cause_reg;
   logic [7:0] cause_next;
   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   logic irq_reg;
   logic irq_next;
   logic nmi_reg;
   logic nmi_next;
   logic [5:0] line_act;

   assign line_act = ~irq_sync[5:0];

   always_comb begin
      cause_next = strap_cfg_pkg::CAUSE_RESET;
      cause_next[5:0] = line_act;
      if (timer7_reg) begin
         cause_next[strap_cfg_pkg::BIT_CAUSE7] = i_timer_irq;
      end else begin
         cause_next[strap_cfg_pkg::BIT_CAUSE7] =
            line_act[strap_cfg_pkg::BIT_LINE5] || i_ext_write_bit5;
      end
      // Line 5 reaches the request only through bit 7
      irq_next = |(cause_next & mask_reg & strap_cfg_pkg::CAUSE_RECOG);
      nmi_next = !irq_sync[6];
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cause_reg <= strap_cfg_pkg::CAUSE_RESET;
         irq_reg <= 1'b0;
         nmi_reg <= 1'b0;
      end else begin
         cause_reg <= cause_next;
         irq_reg <= irq_next;
         nmi_reg <= nmi_next;
      end
   end

   assign o_cause = cause_reg;
   assign o_irq_req = irq_reg;
   assign o_nmi_req = nmi_reg;

   ////////////////////////////////////////////////////////////////////////
   // Register port

   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] status_word;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[8:0] = strap_reg;
      status_word[strap_cfg_pkg::BIT_PROTOCOL +: 3] = proto_reg;
      status_word[strap_cfg_pkg::BIT_BLOCK_EN] = block_reg;
      status_word[strap_cfg_pkg::BIT_RATIO_X2 +: 4] = ratio_reg;
      // Either reset wipes the mask; a warm one keeps the straps
      mask_next = mask_reg;
      if (cold_act || warm_act) begin
         mask_next = strap_cfg_pkg::MASK_RESET;
      end else if (i_wr && i_addr == strap_cfg_pkg::OFF_MASK) begin
         mask_next = i_wdata[7:0];
      end
      rdata_next = 32'h0000_0000;
      if (i_rd) begin
         unique case (i_addr)
            strap_cfg_pkg::OFF_STRAP: rdata_next = status_word;
            strap_cfg_pkg::OFF_CAUSE: rdata_next = {24'h00_0000, cause_reg};
            strap_cfg_pkg::OFF_MASK: rdata_next = {24'h00_0000, mask_reg};
            strap_cfg_pkg::OFF_RSTAT: rdata_next = {30'h0, rstat_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         mask_reg <= strap_cfg_pkg::MASK_RESET;
         rdata_reg <= 32'h0000_0000;
      end else begin
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   property p_ratio;
      cold_act |=> (ratio_reg ==
         strap_cfg_pkg::ratio_x2($past(strap_sync[2:0])));
   endproperty
   a_ratio: assert property (p_ratio)
      else $error("ratio not decoded from captured code");

   property p_endian;
      cold_act |=> (o_big_endian == $past(strap_sync[3]));
   endproperty
   a_endian: assert property (p_endian)
      else $error("byte order does not follow strap");

   property p_width;
      o_high_half_en == strap_reg[strap_cfg_pkg::BIT_BUS_WIDTH];
   endproperty
   a_width: assert property (p_width)
      else $error("bus width does not follow strap");

   property p_bit7_timer;
      !cold_act && timer7_reg && i_timer_irq |=> cause_reg[7];
   endproperty
   a_bit7_timer: assert property (p_bit7_timer)
      else $error("timer not seen on cause bit 7");

   property p_valid_hold;
      hold_reg && i_addr_stall |-> !o_output_valid_n;
   endproperty
   a_valid_hold: assert property (p_valid_hold)
      else $error("output valid dropped during held stall");

   property p_valid_issue;
      !hold_reg && !i_addr_issue |-> o_output_valid_n;
   endproperty
   a_valid_issue: assert property (p_valid_issue)
      else $error("output valid outside issue cycle");

   property p_block;
      o_block_xfer_en |-> !o_bus_64 && !strap_reg[7];
   endproperty
   a_block: assert property (p_block)
      else $error("block transfer enabled wrongly");

   property p_ooo;
      !cold_act && !strap_reg[8] |-> ##1
         o_protocol == 3'(strap_cfg_pkg::PROTO_OUT_OF_ORDER) && !o_in_order;
   endproperty
   a_ooo: assert property (p_ooo)
      else $error("low return strap not out-of-order");

   property p_cause_lines;
      !i_rst ##1 1'b1 |-> o_cause[5:0] == ~$past(irq_sync[5:0]);
   endproperty
   a_cause_lines: assert property (p_cause_lines)
      else $error("cause does not show line levels");

   property p_nmi;
      !irq_sync[6] |=> o_nmi_req;
   endproperty
   a_nmi: assert property (p_nmi)
      else $error("nmi suppressed");

   property p_frozen;
      !cold_act |=> $stable(strap_reg);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("straps changed after capture");

   property p_reset_mask;
      cold_act || warm_act |=> mask_reg == strap_cfg_pkg::MASK_RESET;
   endproperty
   a_reset_mask: assert property (p_reset_mask)
      else $error("mask not cleared by reset");

   c_capture_done: cover property (cold_act ##1 !cold_act);
   c_irq_raised: cover property (!o_irq_req ##1 o_irq_req);
   c_held_stall: cover property (i_addr_issue ##1 i_addr_stall && hold_reg);
   c_warm: cover property (!cold_act && warm_act);

endmodule

// ### tb/board_model.sv
// Board side model: strap wiring, reset buttons and interrupt sources.
// Assumes the bench steers its requests on rising system clock edges.
`timescale 1ns/1ps
module board_model (
   input wire logic i_sys_clk,
   input wire logic [8:0] i_strap_set,
   input wire logic i_break_hold,
   input wire logic i_cold_req,
   input wire logic i_warm_req,
   input wire logic [5:0] i_irq_req,
   input wire logic i_nmi_req,
   output logic [8:0] o_strap,
   output logic o_cold_reset_n,
   output logic o_warm_reset_n,
   output logic [5:0] o_irq_line_n,
   output logic o_nmi_n
);
   initial begin
      o_strap = 9'h000;
      o_cold_reset_n = 1'b0;
      o_warm_reset_n = 1'b1;
      o_irq_line_n = 6'h3f;
      o_nmi_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // Straps move only under cold reset unless told to misbehave
   always @(posedge i_sys_clk) begin
      if (!o_cold_reset_n || i_break_hold) begin
         o_strap <= i_strap_set;
      end
      o_cold_reset_n <= !i_cold_req;
      o_warm_reset_n <= !i_warm_req;
      o_irq_line_n <= ~i_irq_req;
      o_nmi_n <= !i_nmi_req;
   end
endmodule

// ### tb/test_reset_strap_config_capture.sv
// Bench for the strap capture block: straps, resets, interrupts.
// Assumes the board model drives every pin of the far side.
`timescale 1ns/1ps
module test_reset_strap_config_capture;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [8:0] strap_set = 9'h000;
   logic break_hold = 1'b0, cold_req = 1'b1, warm_req = 1'b0;
   logic nmi_req = 1'b0, timer = 1'b0, ext5 = 1'b0;
   logic issue = 1'b0, stall = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [5:0] irq_req = 6'h00;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, word;
   logic [8:0] strap;
   logic cold_n, warm_n, nmi_n, big_endian, bus_64, high_half, blk_en;
   logic vhold, in_order, cold_init, warm_init, ovalid_n, irq_o, nmi_o;
   logic [5:0] irq_n;
   logic [3:0] ratio_x2;
   logic [2:0] proto;
   logic [7:0] cause;
   logic [7:0] m = 8'h95;
   int errors = 0;
   int tests_run = 0;
   logic [8:0] cfgs [5] = '{9'h1ff, 9'h1c0, 9'h0f3, 9'h152, 9'h12d};

   always #(strap_cfg_pkg::CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;

   board_model i_board (
      .i_sys_clk(i_sys_clk),
      .i_strap_set(strap_set),
      .i_break_hold(break_hold),
      .i_cold_req(cold_req),
      .i_warm_req(warm_req),
      .i_irq_req(irq_req),
      .i_nmi_req(nmi_req),
      .o_strap(strap),
      .o_cold_reset_n(cold_n),
      .o_warm_reset_n(warm_n),
      .o_irq_line_n(irq_n),
      .o_nmi_n(nmi_n)
   );

   reset_strap_config_capture i_dut (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_clock_ratio_strap(strap[2:0]),
      .i_byte_order_strap(strap[3]),
      .i_bus_width_strap(strap[4]),
      .i_irq_source_strap(strap[5]),
      .i_valid_delay_strap_n(strap[6]),
      .i_block_xfer_strap_n(strap[7]),
      .i_return_order_strap_n(strap[8]),
      .i_cold_reset_n(cold_n),
      .i_warm_reset_n(warm_n),
      .i_irq_line_n(irq_n),
      .i_nmi_n(nmi_n),
      .i_timer_irq(timer),
      .i_ext_write_bit5(ext5),
      .i_addr_issue(issue),
      .i_addr_stall(stall),
      .i_addr(addr),
      .i_wdata(wdata),
      .i_wr(wr),
      .i_rd(rd),
      .o_rdata(rdata),
      .o_clock_ratio_x2(ratio_x2),
      .o_big_endian(big_endian),
      .o_bus_64(bus_64),
      .o_high_half_en(high_half),
      .o_block_xfer_en(blk_en),
      .o_valid_hold(vhold),
      .o_in_order(in_order),
      .o_protocol(proto),
      .o_cold_init(cold_init),
      .o_warm_init(warm_init),
      .o_output_valid_n(ovalid_n),
      .o_cause(cause),
      .o_irq_req(irq_o),
      .o_nmi_req(nmi_o)
   );

   ////////////////////////////////////////////////////////////
   task automatic chk_bit(input logic got, input logic exp, input string s);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD at %0t: %s got %b exp %b", $time, s, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                           input string s);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge i_sys_clk);
      wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge i_sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   function automatic logic [2:0] exp_proto(input logic [8:0] s);
      if (!s[8]) return 3'h3;
      case ({s[7], s[6], s[4]})
         3'b111: return 3'h0;
         3'b110: return 3'h1;
         3'b000: return 3'h2;
         default: return 3'h4;
      endcase
   endfunction

   task automatic cold_cycle(input logic [8:0] s);
      @(posedge i_sys_clk);
      strap_set <= s;
      cold_req <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      cold_req <= 1'b0;
      #1;
      chk_bit(cold_init, 1'b1, "cold init");
      repeat (6) @(posedge i_sys_clk);
      #1;
      chk_bit(cold_init, 1'b0, "cold done");
   endtask

   task automatic check_cfg(input logic [8:0] s);
      logic [3:0] r;
      logic b;
      r = 4'h4 + {1'b0, s[2:0]};
      b = !s[7] && !s[4];
      rd_reg(strap_cfg_pkg::OFF_STRAP, word);
      chk_word(word, {12'h000, r, 3'h0, b, exp_proto(s), s}, "status");
      chk_word({28'h0, ratio_x2}, {28'h0, r}, "ratio");
      chk_bit(big_endian, s[3], "endian");
      chk_bit(bus_64, s[4], "width");
      chk_bit(high_half, s[4], "upper lanes");
      chk_bit(blk_en, b, "block xfer");
      chk_bit(in_order, s[8], "order");
      chk_word({29'h0, proto}, {29'h0, exp_proto(s)}, "protocol");
      chk_bit(vhold, s[6], "valid hold");
      // Issue first, then a stall, so the held-stall case is reached when the valid-delay strap (s[6]) is high
      @(posedge i_sys_clk);
      issue <= 1'b1;
      #1;
      chk_bit(ovalid_n, 1'b0, "issue valid");
      @(posedge i_sys_clk);
      issue <= 1'b0;
      stall <= 1'b1;
      #1;
      chk_bit(ovalid_n, !s[6], "stall valid");
      @(posedge i_sys_clk);
      stall <= 1'b0;
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Generous span; the sequence needs well under a thousand cycles
   initial begin
      #(5000 * strap_cfg_pkg::CLK_PERIOD_NS);
      errors++;
      $display("BAD at %0t: watchdog expired", $time);
      stop_test;
   end

   initial begin
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk_word({24'h000000, cause}, 32'h0, "reset cause");
      chk_bit(warm_init, 1'b1, "reset warm");
      @(posedge i_sys_clk);
      i_rst <= 1'b0;
      // No false line or nmi request in the first cycles after reset
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk_word({24'h0, cause}, 32'h0, "cause after reset");
      chk_bit(nmi_o, 1'b0, "nmi after reset");
      chk_bit(irq_o, 1'b0, "irq after reset");
      foreach (cfgs[i]) begin
         cold_cycle(cfgs[i]);
         check_cfg(cfgs[i]);
      end
      $display("test straps done");
      @(posedge i_sys_clk);
      break_hold <= 1'b1;
      strap_set <= ~cfgs[4];
      repeat (4) @(posedge i_sys_clk);
      break_hold <= 1'b0;
      check_cfg(cfgs[4]);
      wr_reg(strap_cfg_pkg::OFF_RSTAT, 32'h3);
      rd_reg(strap_cfg_pkg::OFF_RSTAT, word);
      chk_word(word, 32'h0, "flags cleared");
      wr_reg(strap_cfg_pkg::OFF_MASK, 32'h95);
      @(posedge i_sys_clk);
      warm_req <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      #1;
      chk_bit(warm_init, 1'b1, "warm init");
      wr_reg(strap_cfg_pkg::OFF_MASK, 32'hff);
      warm_req <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      rd_reg(strap_cfg_pkg::OFF_MASK, word);
      chk_word(word, 32'h0, "mask after warm");
      rd_reg(strap_cfg_pkg::OFF_RSTAT, word);
      chk_word(word, 32'h2, "warm flag");
      check_cfg(cfgs[4]);
      cold_cycle(cfgs[4]);
      $display("test capture done");
      wr_reg(strap_cfg_pkg::OFF_MASK, {24'h0, m});
      rd_reg(strap_cfg_pkg::OFF_MASK, word);
      chk_word(word, {24'h0, m}, "mask");
      for (int i = 0; i < 6; i++) begin
         irq_req <= 6'h01 << i;
         repeat (5) @(posedge i_sys_clk);
         rd_reg(strap_cfg_pkg::OFF_CAUSE, word);
         chk_word(word, 32'h1 << i, "cause line");
         chk_bit(irq_o, (i < 5) && m[i], "line request");
      end
      irq_req <= 6'h00;
      timer <= 1'b1;
      repeat (5) @(posedge i_sys_clk);
      #1;
      chk_word({24'h0, cause}, 32'h80, "timer cause");
      chk_bit(irq_o, 1'b1, "timer request");
      rd_reg(4'h2, word);
      chk_word(word, 32'h0, "unmapped");
      @(posedge i_sys_clk);
      #1;
      chk_word(rdata, 32'h0, "idle data");
      cold_cycle(cfgs[1]);
      wr_reg(strap_cfg_pkg::OFF_MASK, 32'h80);
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk_word({24'h0, cause}, 32'h0, "timer off");
      irq_req <= 6'h20;
      repeat (5) @(posedge i_sys_clk);
      #1;
      chk_word({24'h0, cause}, 32'ha0, "line 5 cause");
      chk_bit(irq_o, 1'b1, "line 5 request");
      irq_req <= 6'h00;
      ext5 <= 1'b1;
      repeat (5) @(posedge i_sys_clk);
      #1;
      chk_word({24'h0, cause}, 32'h80, "write bit 5");
      ext5 <= 1'b0;
      wr_reg(strap_cfg_pkg::OFF_MASK, 32'h0);
      irq_req <= 6'h01;
      nmi_req <= 1'b1;
      repeat (5) @(posedge i_sys_clk);
      #1;
      chk_bit(irq_o, 1'b0, "masked");
      chk_bit(nmi_o, 1'b1, "nmi");
      $display("test irq done");
      stop_test;
   end
endmodule
